// ===== rtl/mss_pkg.sv
// shared constants, types and parameter map of the motion step sequencer
package mss_pkg;
    // parameter slots: slot k is parameter number 700+k, byte address 4*k
    localparam int NUM_GROUPS = 8;
    localparam int SLOTS_PER_GROUP = 8;
    localparam int NUM_SLOTS = 72;
    localparam logic [2:0] SL_TYPE = 3'h0;
    localparam logic [2:0] SL_POS_LO = 3'h1;
    localparam logic [2:0] SL_POS_HI = 3'h2;
    localparam logic [2:0] SL_SPEED = 3'h3;
    localparam logic [2:0] SL_MODE = 3'h4;
    localparam logic [2:0] SL_COND1 = 3'h5;
    localparam logic [2:0] SL_COND2 = 3'h6;
    localparam logic [2:0] SL_NEXT = 3'h7;
    localparam int SL_START_MODE = 64;
    localparam int SL_ACCEL = 65;
    localparam int SL_DECEL = 66;
    localparam int SL_FILT = 67;
    localparam int SL_GNUM_LO = 68;
    localparam int SL_GNUM_HI = 69;
    localparam int SL_GDEN_LO = 70;
    localparam int SL_GDEN_HI = 71;
    // reset values of the global slots and of the control word
    localparam logic [15:0] RST_ACCEL = 16'h2710;
    localparam logic [15:0] RST_DECEL = 16'h2710;
    localparam logic [15:0] RST_FILT = 16'h0001;
    localparam logic [15:0] RST_GEAR_LO = 16'h0001;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    // bus map beyond the slots
    localparam int ADR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h140;
    localparam logic [11:0] ADDR_STAT = 12'h144;
    // fields of the mode word, one hex digit each
    localparam int MF_C1_LSB = 0;
    localparam int MF_C2_LSB = 4;
    localparam int MF_COMB_LSB = 8;
    localparam int MF_TRANS_LSB = 12;
    // condition types and value codes
    localparam logic [3:0] CT_NONE = 4'h0;
    localparam logic [3:0] CT_DELAY = 4'h1;
    localparam logic [3:0] CT_EDGE = 4'h2;
    localparam logic [3:0] CT_LEVEL = 4'h3;
    localparam logic [15:0] EV_RISE = 16'h0000;
    localparam logic [15:0] EV_FALL = 16'h0001;
    localparam logic [15:0] EV_BOTH = 16'h0002;
    localparam logic [15:0] LV_HIGH = 16'h0003;
    localparam logic [15:0] LV_LOW = 16'h0004;
    localparam logic [3:0] CB_ONE = 4'h0;
    localparam logic [3:0] CB_AND = 4'h1;
    localparam logic [3:0] CB_OR = 4'h2;
    localparam logic [3:0] TM_ABORT = 4'h0;
    localparam logic [3:0] TM_STANDARD = 4'h1;
    localparam logic [3:0] TM_BUFFERED = 4'h2;
    localparam logic [3:0] TM_BLEND = 4'h3;
    localparam logic [15:0] GT_INVALID = 16'h0000;
    localparam logic [15:0] GT_REL = 16'h0002;
    // timing
    localparam int CLK_HZ = 100000000;
    localparam int TIMEBASE_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / 1000 * TIMEBASE_MS;
    localparam int FILT_UNIT_US = 100;
    localparam int CYC_PER_FILT = CLK_HZ / 1000000 * FILT_UNIT_US;
    localparam logic [15:0] FILT_MAX = 16'h03e8;
    localparam logic [15:0] DELAY_MAX = 16'hffff;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOAD = 4'h2,
        ST_RUN = 4'h4,
        ST_HALT = 4'h8
    } mss_state_t;

    typedef struct packed {
        logic [2:0] grp;
        logic rel;
        logic [31:0] pos;
        logic [15:0] speed;
    } mss_cmd_t;

    function automatic logic [15:0] mss_slot_reset(input int idx);
        case (idx)
            SL_ACCEL: return RST_ACCEL;
            SL_DECEL: return RST_DECEL;
            SL_FILT: return RST_FILT;
            SL_GNUM_LO: return RST_GEAR_LO;
            SL_GDEN_LO: return RST_GEAR_LO;
            default: return 16'h0000;
        endcase
    endfunction
endpackage

// ===== rtl/mss_sequencer.sv
// motion step sequencer: parameter table, wishbone slave and step chain control
`timescale 1ns/1ps
module mss_sequencer #(
    parameter int CYC_PER_MS = mss_pkg::CYC_PER_MS,
    parameter int CYC_PER_FILT = mss_pkg::CYC_PER_FILT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mss_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic run_permit_i,
    input wire logic step_i,
    input wire logic in_place_i,
    input wire logic target_reached_i,
    output logic motion_enable_o,
    output mss_pkg::mss_cmd_t cmd_o,
    output logic motion_start_o,
    output logic stop_o,
    output logic blend_o,
    output logic invalid_o
);
    logic [15:0] par_q [0:mss_pkg::NUM_SLOTS-1];
    logic [15:0] ctrl_q;
    mss_pkg::mss_state_t state_q;
    logic [2:0] grp_q;
    logic en_q;
    logic [31:0] ms_cnt_q;
    logic ms_tick;
    logic step_f;
    logic step_prev_q;
    logic step_rise;
    logic step_fall;
    logic [1:0] cond_ok;
    logic step_ok;
    logic [15:0] g_type;
    logic [15:0] g_mode;
    logic [15:0] g_next;
    logic [3:0] comb;
    logic [3:0] trans;
    logic advance;
    logic req;
    logic [9:0] widx;

    // bus request that has not been answered yet
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign widx = wb_adr_i[mss_pkg::ADR_W-1:2];

    // fields of the running group
    assign g_type = par_q[{grp_q, mss_pkg::SL_TYPE}];
    assign g_mode = par_q[{grp_q, mss_pkg::SL_MODE}];
    assign g_next = par_q[{grp_q, mss_pkg::SL_NEXT}];
    assign comb = g_mode[mss_pkg::MF_COMB_LSB +: 4];
    assign trans = g_mode[mss_pkg::MF_TRANS_LSB +: 4];

    // ack one cycle after the request, dropped in the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // parameter table writes, low two byte lanes only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < mss_pkg::NUM_SLOTS; i++) begin
                par_q[i] <= mss_pkg::mss_slot_reset(i);
            end
        end else if (req && wb_we_i && widx < 10'(mss_pkg::NUM_SLOTS)) begin
            if (wb_sel_i[0]) begin
                par_q[widx[6:0]][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                par_q[widx[6:0]][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // control word: start group in the low bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= mss_pkg::RST_CTRL;
        end else if (req && wb_we_i && wb_adr_i == mss_pkg::ADDR_CTRL) begin
            if (wb_sel_i[0]) begin
                ctrl_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ctrl_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // read mux; unmapped addresses read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            if (widx < 10'(mss_pkg::NUM_SLOTS)) begin
                wb_dat_o <= {16'h0, par_q[widx[6:0]]};
            end else if (wb_adr_i == mss_pkg::ADDR_CTRL) begin
                wb_dat_o <= {16'h0, ctrl_q};
            end else if (wb_adr_i == mss_pkg::ADDR_STAT) begin
                wb_dat_o <= {23'h0, state_q, grp_q, invalid_o, en_q};
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end

    // millisecond timebase, free running
    assign ms_tick = (ms_cnt_q == 32'(CYC_PER_MS - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i || ms_tick) begin
            ms_cnt_q <= 32'h0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h1;
        end
    end

    mss_step_filter #(
        .CYC_PER_UNIT(CYC_PER_FILT)
    ) u_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(step_i),
        .time_i(par_q[mss_pkg::SL_FILT]),
        .filt_o(step_f)
    );

    // edge detection on the qualified step input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_prev_q <= 1'b0;
        end else begin
            step_prev_q <= step_f;
        end
    end
    assign step_rise = step_f && !step_prev_q;
    assign step_fall = !step_f && step_prev_q;

    // each step condition gets its own copy of the same evaluator
    for (genvar ci = 0; ci < 2; ci++) begin : g_cond
        logic [15:0] dly_q;
        logic rise_q;
        logic fall_q;
        logic [3:0] ctype;
        logic [15:0] cval;
        logic ok;

        assign ctype = g_mode[(ci == 0 ? mss_pkg::MF_C1_LSB : mss_pkg::MF_C2_LSB) +: 4];
        assign cval = par_q[{grp_q, (ci == 0) ? mss_pkg::SL_COND1 : mss_pkg::SL_COND2}];

        // delay count only advances while the group runs and motion is permitted
        always_ff @(posedge clk_i) begin
            if (rst_i || state_q == mss_pkg::ST_LOAD) begin
                dly_q <= 16'h0;
            end else if (state_q == mss_pkg::ST_RUN && en_q && ms_tick && dly_q != mss_pkg::DELAY_MAX) begin
                dly_q <= dly_q + 16'h1;
            end
        end

        // edges are remembered so a short pulse while waiting is not lost
        always_ff @(posedge clk_i) begin
            if (rst_i || state_q == mss_pkg::ST_LOAD) begin
                rise_q <= 1'b0;
                fall_q <= 1'b0;
            end else if (state_q == mss_pkg::ST_RUN) begin
                rise_q <= rise_q || step_rise;
                fall_q <= fall_q || step_fall;
            end
        end

        // condition value decoded by its type
        always_comb begin
            ok = 1'b0;
            case (ctype)
                mss_pkg::CT_NONE: ok = 1'b1;
                mss_pkg::CT_DELAY: ok = (dly_q >= cval);
                mss_pkg::CT_EDGE: begin
                    if (cval == mss_pkg::EV_RISE) begin
                        ok = rise_q;
                    end else if (cval == mss_pkg::EV_FALL) begin
                        ok = fall_q;
                    end else if (cval == mss_pkg::EV_BOTH) begin
                        ok = rise_q || fall_q;
                    end
                end
                mss_pkg::CT_LEVEL: begin
                    if (cval == mss_pkg::LV_HIGH) begin
                        ok = step_f;
                    end else if (cval == mss_pkg::LV_LOW) begin
                        ok = !step_f;
                    end
                end
                default: ok = 1'b0;
            endcase
        end
        assign cond_ok[ci] = ok;
    end

    // combination of the two conditions; unknown settings never satisfy the step condition
    always_comb begin
        case (comb)
            mss_pkg::CB_ONE: step_ok = cond_ok[0];
            mss_pkg::CB_AND: step_ok = cond_ok[0] && cond_ok[1];
            mss_pkg::CB_OR: step_ok = cond_ok[0] || cond_ok[1];
            default: step_ok = 1'b0;
        endcase
    end

    // transition decision; core status still belongs to the old command while the start pulse stands
    always_comb begin
        case (trans)
            mss_pkg::TM_ABORT: advance = 1'b1;
            mss_pkg::TM_STANDARD: advance = in_place_i && step_ok && !motion_start_o;
            mss_pkg::TM_BUFFERED: advance = target_reached_i && step_ok && !motion_start_o;
            mss_pkg::TM_BLEND: advance = target_reached_i && !motion_start_o;
            default: advance = 1'b0;
        endcase
    end

    // run permit sampled once; load and run freeze while it is low, halt returns to idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
        end else begin
            en_q <= run_permit_i;
        end
    end
    assign motion_enable_o = en_q;

    // sequencing state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= mss_pkg::ST_IDLE;
            grp_q <= 3'h0;
        end else begin
            case (state_q)
                mss_pkg::ST_IDLE: begin
                    // start only on the permit going high
                    if (run_permit_i && !en_q) begin
                        state_q <= mss_pkg::ST_LOAD;
                        grp_q <= ctrl_q[2:0];
                    end
                end
                mss_pkg::ST_LOAD: begin
                    if (en_q) begin
                        state_q <= (g_type == mss_pkg::GT_INVALID) ? mss_pkg::ST_HALT : mss_pkg::ST_RUN;
                    end
                end
                mss_pkg::ST_RUN: begin
                    if (en_q && advance) begin
                        state_q <= mss_pkg::ST_LOAD;
                        grp_q <= g_next[2:0];
                    end
                end
                mss_pkg::ST_HALT: begin
                    if (!en_q) begin
                        state_q <= mss_pkg::ST_IDLE;
                    end
                end
                default: state_q <= mss_pkg::ST_IDLE;
            endcase
        end
    end

    // command latch and one-cycle strobes toward the motion core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_o <= '0;
            motion_start_o <= 1'b0;
            stop_o <= 1'b0;
            blend_o <= 1'b0;
        end else begin
            motion_start_o <= 1'b0;
            stop_o <= 1'b0;
            blend_o <= 1'b0;
            if (state_q == mss_pkg::ST_LOAD && en_q && g_type != mss_pkg::GT_INVALID) begin
                cmd_o.grp <= grp_q;
                cmd_o.rel <= (g_type == mss_pkg::GT_REL);
                cmd_o.pos <= {par_q[{grp_q, mss_pkg::SL_POS_HI}], par_q[{grp_q, mss_pkg::SL_POS_LO}]};
                cmd_o.speed <= par_q[{grp_q, mss_pkg::SL_SPEED}];
                motion_start_o <= 1'b1;
            end
            if (state_q == mss_pkg::ST_RUN && en_q && advance) begin
                stop_o <= (trans == mss_pkg::TM_ABORT);
                blend_o <= (trans == mss_pkg::TM_BLEND);
            end
        end
    end

    // invalid group flag, kept until the next start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            invalid_o <= 1'b0;
        end else if (state_q == mss_pkg::ST_LOAD && en_q) begin
            invalid_o <= (g_type == mss_pkg::GT_INVALID);
        end
    end

    property p_ack_drop;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

    property p_invalid_halt;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == mss_pkg::ST_LOAD && en_q && g_type == mss_pkg::GT_INVALID)
            |=> (state_q == mss_pkg::ST_HALT && invalid_o && !motion_start_o);
    endproperty
    a_invalid_halt: assert property (p_invalid_halt) else $error("invalid group not halted");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == mss_pkg::ST_RUN && en_q && trans == mss_pkg::TM_ABORT)
            |=> (stop_o && state_q == mss_pkg::ST_LOAD) ##1 (!stop_o);
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop and reload");

    property p_standard_wait;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == mss_pkg::ST_RUN && trans == mss_pkg::TM_STANDARD && (!in_place_i || !step_ok))
            |=> state_q == mss_pkg::ST_RUN;
    endproperty
    a_standard_wait: assert property (p_standard_wait) else $error("standard stepped too early");

    property p_buffered_wait;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == mss_pkg::ST_RUN && trans == mss_pkg::TM_BUFFERED && (!target_reached_i || !step_ok))
            |=> state_q == mss_pkg::ST_RUN;
    endproperty
    a_buffered_wait: assert property (p_buffered_wait) else $error("buffered stepped too early");

    property p_blend;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == mss_pkg::ST_RUN && en_q && run_permit_i && trans == mss_pkg::TM_BLEND && target_reached_i
                && !motion_start_o)
            |=> (blend_o && !stop_o && state_q == mss_pkg::ST_LOAD) ##1 (motion_start_o ^ invalid_o);
    endproperty
    a_blend: assert property (p_blend) else $error("blend did not hand over");

    property p_successor;
        @(posedge clk_i) disable iff (rst_i)
            ($past(state_q) == mss_pkg::ST_RUN && state_q == mss_pkg::ST_LOAD) |-> grp_q == $past(g_next[2:0]);
    endproperty
    a_successor: assert property (p_successor) else $error("wrong successor group");

    property p_suspend;
        @(posedge clk_i) disable iff (rst_i)
            (!run_permit_i && state_q != mss_pkg::ST_IDLE) |=> (!motion_enable_o ##1 !motion_start_o);
    endproperty
    a_suspend: assert property (p_suspend) else $error("motion not suspended");

    property p_and_comb;
        @(posedge clk_i) disable iff (rst_i)
            (comb == mss_pkg::CB_AND && !cond_ok[1]) |-> !step_ok;
    endproperty
    a_and_comb: assert property (p_and_comb) else $error("and combination ignored condition 2");

    property p_delay_hold;
        @(posedge clk_i) disable iff (rst_i)
            (state_q == mss_pkg::ST_RUN && g_mode[mss_pkg::MF_C1_LSB +: 4] == mss_pkg::CT_DELAY && cond_ok[0])
            |-> g_cond[0].dly_q >= par_q[{grp_q, mss_pkg::SL_COND1}];
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("delay condition held early");

    c_abort: cover property (@(posedge clk_i) disable iff (rst_i) stop_o);
    c_blend: cover property (@(posedge clk_i) disable iff (rst_i) blend_o);
    c_invalid: cover property (@(posedge clk_i) disable iff (rst_i) invalid_o);
    c_chain: cover property (@(posedge clk_i) disable iff (rst_i) motion_start_o ##[1:20] motion_start_o);
endmodule

// ===== rtl/mss_step_filter.sv
// digital filter that qualifies the step input level
`timescale 1ns/1ps
module mss_step_filter #(
    parameter int CYC_PER_UNIT = mss_pkg::CYC_PER_FILT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    input wire logic [15:0] time_i,
    output logic filt_o
);
    logic [31:0] sub_q;
    logic [15:0] units_q;
    logic [15:0] lim;

    // time above the range is clamped to the top of the range
    assign lim = (time_i > mss_pkg::FILT_MAX) ? mss_pkg::FILT_MAX : time_i;

    // restart the qualification window whenever input equals output
    always_ff @(posedge clk_i) begin
        if (rst_i || raw_i == filt_o) begin
            sub_q <= 32'h0;
            units_q <= 16'h0;
        end else if (sub_q == 32'(CYC_PER_UNIT - 1)) begin
            sub_q <= 32'h0;
            units_q <= units_q + 16'h1;
        end else begin
            sub_q <= sub_q + 32'h1;
        end
    end

    // accept the new level once it stood for the programmed time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_o <= 1'b0;
        end else if (raw_i != filt_o && units_q >= lim) begin
            filt_o <= raw_i;
        end
    end
endmodule

// ===== tb/motion_step_sequencer_bench.sv
// bench for the motion step sequencer: register table, condition table, suspension, reset
`timescale 1ns/1ps
module motion_step_sequencer_bench;
    typedef struct packed {logic [11:0] a; logic w; logic [15:0] d;} mss_reg_t;
    typedef struct packed {logic [15:0] m; logic [15:0] c1; logic [15:0] c2; logic [2:0] f; logic [7:0] lo;} mss_case_t;
    logic clk_i, rst_i, cyc, stb, we, ack, permit, step, tgt, inp, en, start, stop, blend, inv;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o;
    logic [15:0] q;
    mss_pkg::mss_cmd_t cmd;
    int n_errors = 0, checks_done = 0, n;
    logic fs, fb;
    // read rows carry the expected value in d; unmapped 0x180 must read back zero
    mss_reg_t rr [17] = '{'{12'h104, 1'b0, 16'h2710}, '{12'h108, 1'b0, 16'h2710}, '{12'h10c, 1'b0, 16'h0001},
        '{12'h110, 1'b0, 16'h0001}, '{12'h118, 1'b0, 16'h0001}, '{12'h014, 1'b0, 16'h0000},
        '{12'h118, 1'b1, 16'h0003}, '{12'h118, 1'b0, 16'h0003}, '{12'h180, 1'b1, 16'hbeef},
        '{12'h180, 1'b0, 16'h0000}, '{12'h10c, 1'b1, 16'h0000}, '{12'h000, 1'b1, 16'h0001},
        '{12'h004, 1'b1, 16'h2345}, '{12'h008, 1'b1, 16'h0001}, '{12'h01c, 1'b1, 16'h0001},
        '{12'h020, 1'b0, 16'h0000}, '{12'h01c, 1'b0, 16'h0001}};
    // f is {step before start, step after start, advance expected}; lo is the least cycles to advance
    mss_case_t cs [15] = '{'{16'h1002, 16'h0000, 16'h0000, 3'h3, 8'h00}, '{16'h1002, 16'h0001, 16'h0000, 3'h2, 8'h00},
        '{16'h1002, 16'h0002, 16'h0000, 3'h5, 8'h00}, '{16'h1002, 16'h0005, 16'h0000, 3'h2, 8'h00},
        '{16'h1003, 16'h0003, 16'h0000, 3'h7, 8'h00}, '{16'h1003, 16'h0004, 16'h0000, 3'h6, 8'h00},
        '{16'h1123, 16'h0003, 16'h0000, 3'h3, 8'h00}, '{16'h1123, 16'h0004, 16'h0000, 3'h2, 8'h00},
        '{16'h1223, 16'h0004, 16'h0000, 3'h3, 8'h00}, '{16'h1000, 16'h0005, 16'h0000, 3'h7, 8'h08},
        '{16'h1030, 16'h0000, 16'h0004, 3'h7, 8'h00}, '{16'h2001, 16'h0014, 16'h0000, 3'h1, 8'hb4},
        '{16'h3002, 16'h0001, 16'h0000, 3'h1, 8'h00}, '{16'h0003, 16'h0004, 16'h0000, 3'h7, 8'h00},
        '{16'h1002, 16'h0007, 16'h0000, 3'h2, 8'h00}};

    mss_sequencer #(.CYC_PER_MS(10), .CYC_PER_FILT(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .run_permit_i(permit), .step_i(step), .in_place_i(inp), .target_reached_i(tgt),
        .motion_enable_o(en), .cmd_o(cmd), .motion_start_o(start), .stop_o(stop), .blend_o(blend),
        .invalid_o(inv));
    mss_core_model core (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .stop_i(stop), .dly_i(8'h03),
        .target_reached_o(tgt), .in_place_o(inp));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask

    // classic cycle: hold everything until ack is sampled, then release for one cycle
    task automatic wb(input logic [11:0] a, input logic w, input logic [15:0] d);
        int i;
        i = 0;
        adr <= a; we <= w; dat <= {16'h0000, d}; sel <= 4'h3; cyc <= 1'b1; stb <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1 && i < 50) begin
            @(posedge clk_i);
            i++;
        end
        q = dat_o[15:0];
        chk("ack", 32'h1, {31'h0, ack});
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // count cycles until the invalid successor is loaded, noting abort and blend pulses
    task automatic wait_inv(input int lim);
        n = 0; fs = 1'b0; fb = 1'b0;
        while (inv !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
            fs |= (stop === 1'b1);
            fb |= (blend === 1'b1);
        end
    endtask

    task automatic go();
        permit <= 1'b1;
        n = 0;
        while (start !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk("start", 32'h1, {31'h0, start});
        chk("grp", 32'h0, {29'h0, cmd.grp});
        chk("pos", 32'h00012345, cmd.pos);
        chk("rel", 32'h0, {31'h0, cmd.rel});
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0; dat = 32'h0;
        permit = 1'b0; step = 1'b0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rr[k]) begin
            wb(rr[k].a, rr[k].w, rr[k].d);
            if (!rr[k].w) chk("reg", {16'h0, rr[k].d}, {16'h0, q});
        end
        // edges, levels, combine, delay, modes: rules 1 to 9 and 14, one row each
        foreach (cs[k]) begin
            wb(12'h010, 1'b1, cs[k].m);
            wb(12'h014, 1'b1, cs[k].c1);
            wb(12'h018, 1'b1, cs[k].c2);
            step <= cs[k].f[2];
            repeat (4) @(posedge clk_i);
            go();
            step <= cs[k].f[1];
            wait_inv(400);
            chk("advance", {31'h0, cs[k].f[0]}, {31'h0, inv});
            if (cs[k].f[0]) begin
                chk("early", 32'h1, {31'h0, n >= cs[k].lo});
                chk("stop", {31'h0, cs[k].m[15:12] == 4'h0}, {31'h0, fs});
                chk("blend", {31'h0, cs[k].m[15:12] == 4'h3}, {31'h0, fb});
            end
            // a row left waiting is aborted into the invalid successor so the next start finds idle
            wb(12'h010, 1'b1, 16'h0000);
            permit <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        // permit dropped mid-delay: everything freezes, then resumes
        wb(12'h010, 1'b1, 16'h1001);
        wb(12'h014, 1'b1, 16'h000a);
        go();
        permit <= 1'b0;
        wait_inv(150);
        chk("held", 32'h0, {31'h0, inv});
        chk("enable", 32'h0, {31'h0, en});
        permit <= 1'b1;
        wait_inv(200);
        chk("resume", 32'h1, {31'h0, inv});
        // reset while halted on the invalid successor restores table values and clears outputs
        wb(12'h104, 1'b1, 16'h0001);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        permit <= 1'b0;
        @(posedge clk_i);
        chk("outs", 32'h0, {28'h0, inv, en, start, stop});
        wb(12'h104, 1'b0, 16'h0000);
        chk("accel", 32'h2710, {16'h0, q});
        // status after reset: idle state, group 0, no invalid flag, no enable
        wb(12'h144, 1'b0, 16'h0000);
        chk("stat", 32'h0020, {16'h0, q});
        stop_test();
    end
endmodule

// ===== tb/mss_core_model.sv
// motion core stand-in: reports target reached, then in place, after each command
`timescale 1ns/1ps
module mss_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [7:0] dly_i,
    output logic target_reached_o,
    output logic in_place_o
);
    logic [7:0] cnt_q;
    // settle count restarts on each new command or abort, saturates at the top
    always_ff @(posedge clk_i) begin
        if (rst_i || start_i || stop_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // in place lags target by two cycles so standard waits longer than buffered
    assign target_reached_o = (cnt_q >= dly_i);
    assign in_place_o = (cnt_q >= dly_i + 8'h02);
endmodule
